// File: core/eng_defines.vh
`ifndef ENG_DEFINES_VH
`define ENG_DEFINES_VH

// register byte offsets
`define ENG_OFF_FEATURE 8'h00
`define ENG_OFF_CONTROL 8'h08
`define ENG_OFF_STATUS 8'h10
`define ENG_OFF_COUNTER 8'h18

// feature register bit positions
`define ENG_FR_FAULT_IRQ 0
`define ENG_FR_FI_CTL 1
`define ENG_FR_CFI_CTL 2
`define ENG_FR_INBAND 3
`define ENG_FR_UE_CTL 4
`define ENG_FR_UE_SPLIT 5
`define ENG_FR_COUNTER 6
`define ENG_FEATURE_VALUE 32'h0000_007F

// control register bit positions
`define ENG_CTL_FI 0
`define ENG_CTL_CFI 1
`define ENG_CTL_RUE 2
`define ENG_CTL_WUE 3
`define ENG_CTL_RESET 4'h0

// status register bit positions
`define ENG_ST_VALID 0
`define ENG_ST_ER 1
`define ENG_ST_CLASS_LO 4
`define ENG_ST_CLASS_HI 5
`define ENG_ST_SYN_LO 8
`define ENG_ST_SYN_HI 15

// counter register bit positions
`define ENG_CNT_OVERFLOW 8
`define ENG_CNT_RESET 8'h00
`define ENG_CNT_MAX 8'hFF

// error classes
`define ENG_CLASS_NONE 2'h0
`define ENG_CLASS_CE 2'h1
`define ENG_CLASS_DE 2'h2
`define ENG_CLASS_UE 2'h3

// bus responses
`define ENG_RESP_OKAY 2'h0
`define ENG_RESP_SLVERR 2'h2

`endif

// File: core/eng_ce_counter.v
`timescale 1ns/10ps
`include "eng_defines.vh"

module eng_ce_counter (
    // clock and reset
    input wire clk,
    input wire nrst,
    // corrected error seen
    input wire countEn,
    // software access
    input wire wrCount,
    input wire [7:0] wrCountData,
    input wire wrOverflow,
    input wire wrOverflowData,
    // state and event
    output reg [7:0] count,
    output reg overflow,
    output wire ceEvent
);

    wire wrap;

    // an event only on the wrap that sets a clear flag; a wrap onto a set flag is silent
    assign wrap = countEn && (count == `ENG_CNT_MAX);
    assign ceEvent = wrap && !overflow;

    // counter; hardware counting wins over a software write in the same cycle
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= `ENG_CNT_RESET;
        end else if (countEn) begin
            count <= count + 8'h01;
        end else if (wrCount) begin
            count <= wrCountData;
        end
    end

    // overflow flag; software setting it raises no event, a wrap in the same cycle wins
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            overflow <= 1'b0;
        end else if (wrap) begin
            overflow <= 1'b1;
        end else if (wrOverflow) begin
            overflow <= wrOverflowData;
        end
    end

endmodule

// File: core/eng_irq_abort_gating.v
`timescale 1ns/10ps
`include "eng_defines.vh"

module eng_irq_abort_gating (
    // clock and reset
    input wire clk,
    input wire nrst,
    // axi4-lite write address
    input wire awvalid,
    output wire awready,
    input wire [7:0] awaddr,
    // axi4-lite write data
    input wire wvalid,
    output wire wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    // axi4-lite write response
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    // axi4-lite read address
    input wire arvalid,
    output wire arready,
    input wire [7:0] araddr,
    // axi4-lite read data
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    // error report from the protected logic
    input wire errValid,
    input wire [1:0] errClass,
    input wire errIsWrite,
    input wire [7:0] errSyndrome,
    // outputs to the interrupt controller and the requester
    output reg faultIrq,
    output reg abortResp
);

    // write channel holding registers
    reg awHeld;
    reg [7:0] awAddrQ;
    reg wHeld;
    reg [31:0] wDataQ;
    reg [3:0] wStrbQ;
    // control and record state
    reg [3:0] ctl;
    reg recValid;
    reg abortReported;
    reg [1:0] recClass;
    reg [7:0] recSyndrome;
    reg faultPend;
    // decoded write strobes
    wire doWrite;
    wire wrCtl;
    wire wrStatus;
    wire wrCounter;
    wire wrHit;
    // error path
    wire errCe;
    wire errDe;
    wire errUe;
    wire errAny;
    wire takeRecord;
    wire ceEvent;
    wire [7:0] ceCount;
    wire ceOverflow;
    wire ceIrq;
    wire dueIrq;
    wire raiseIrq;
    wire abortEn;
    wire abortNow;
    wire clearValid;
    wire clearEr;
    reg [31:0] next_rdata;
    reg next_rhit;
    // option-aware gating terms
    wire fiOn;
    wire cfiOn;
    wire ceSeen;
    wire abortSel;
    wire [31:0] featureWord;

    // implemented option set; the feature word and all the gating below follow it,
    // so software never finds a control that the logic ignores
    localparam HAS_FAULT_IRQ = 1'b1;
    localparam HAS_FI_CTL = 1'b1;
    localparam HAS_CFI_CTL = 1'b1;
    localparam HAS_INBAND = 1'b1;
    localparam HAS_UE_CTL = 1'b1;
    localparam HAS_UE_SPLIT = 1'b1;
    localparam HAS_COUNTER = 1'b1;

    // feature word built from the option set, one bit per option
    assign featureWord = {25'h000_0000, HAS_COUNTER, HAS_UE_SPLIT, HAS_UE_CTL, HAS_INBAND,
        HAS_CFI_CTL, HAS_FI_CTL, HAS_FAULT_IRQ};

    // a channel is accepted once and held until the pair completes
    assign awready = !awHeld && !bvalid;
    assign wready = !wHeld && !bvalid;
    assign arready = !rvalid;
    assign doWrite = awHeld && wHeld && !bvalid;

    // address and data are latched independently, so either may arrive first
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awHeld <= 1'b0;
            awAddrQ <= 8'h00;
            wHeld <= 1'b0;
            wDataQ <= 32'h0000_0000;
            wStrbQ <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                awAddrQ <= awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    // address decode for writes; the feature register is read only
    assign wrCtl = doWrite && (awAddrQ == `ENG_OFF_CONTROL) && wStrbQ[0];
    assign wrStatus = doWrite && (awAddrQ == `ENG_OFF_STATUS) && wStrbQ[0];
    assign wrCounter = doWrite && (awAddrQ == `ENG_OFF_COUNTER);
    assign wrHit = (awAddrQ == `ENG_OFF_FEATURE) || (awAddrQ == `ENG_OFF_CONTROL) ||
        (awAddrQ == `ENG_OFF_STATUS) || (awAddrQ == `ENG_OFF_COUNTER);

    // write response one cycle after the pair completes; unmapped gets slverr
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bvalid <= 1'b0;
            bresp <= `ENG_RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wrHit ? `ENG_RESP_OKAY : `ENG_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // control register: fault enable, corrected-event enable, split abort enables
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl <= `ENG_CTL_RESET;
        end else if (wrCtl) begin
            ctl <= wDataQ[3:0];
        end
    end

    // error classification from the protected logic
    assign errCe = errValid && (errClass == `ENG_CLASS_CE);
    assign errDe = errValid && (errClass == `ENG_CLASS_DE);
    assign errUe = errValid && (errClass == `ENG_CLASS_UE);
    assign errAny = errCe || errDe || errUe;

    // corrected errors are counted; the interrupt follows the overflow, not each error
    eng_ce_counter u_counter (
        .clk(clk),
        .nrst(nrst),
        .countEn(errCe),
        .wrCount(wrCounter && wStrbQ[0]),
        .wrCountData(wDataQ[7:0]),
        .wrOverflow(wrCounter && wStrbQ[1]),
        .wrOverflowData(wDataQ[`ENG_CNT_OVERFLOW]),
        .count(ceCount),
        .overflow(ceOverflow),
        .ceEvent(ceEvent)
    );

    // corrected events use their own enable, deferred and uncorrected the general one
    // an absent fault or abort enable reads as always on; an absent interrupt never fires
    assign fiOn = HAS_FAULT_IRQ && (!HAS_FI_CTL || ctl[`ENG_CTL_FI]);
    // without its own enable a corrected event falls under the general one
    assign cfiOn = HAS_CFI_CTL ? ctl[`ENG_CTL_CFI] : fiOn;
    // with a counter only the wrap counts, otherwise every corrected record
    assign ceSeen = HAS_COUNTER ? ceEvent : errCe;
    assign ceIrq = ceSeen && cfiOn && HAS_FAULT_IRQ;
    assign dueIrq = (errDe || errUe) && fiOn;
    assign raiseIrq = ceIrq || dueIrq;

    // the syndrome is replaced only by a strictly worse class; the interrupt does not care
    assign takeRecord = errAny && (!recValid || (errClass > recClass));

    // abort for uncorrected errors, enabled separately for reads and writes
    assign abortSel = (errIsWrite && HAS_UE_SPLIT) ? ctl[`ENG_CTL_WUE] : ctl[`ENG_CTL_RUE];
    assign abortEn = HAS_INBAND && (!HAS_UE_CTL || abortSel);
    assign abortNow = errUe && abortEn;

    // status clears are write-one-to-clear on the low byte
    assign clearValid = wrStatus && wDataQ[`ENG_ST_VALID];
    assign clearEr = wrStatus && wDataQ[`ENG_ST_ER];

    // error record; a strictly worse error in the clearing cycle keeps the record valid
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            recValid <= 1'b0;
            recClass <= `ENG_CLASS_NONE;
            recSyndrome <= 8'h00;
        end else if (takeRecord) begin
            recValid <= 1'b1;
            recClass <= errClass;
            recSyndrome <= errSyndrome;
        end else if (clearValid) begin
            recValid <= 1'b0;
            recClass <= `ENG_CLASS_NONE;
            recSyndrome <= 8'h00;
        end
    end

    // reported flag, set wins over the clear
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            abortReported <= 1'b0;
        end else if (abortNow) begin
            abortReported <= 1'b1;
        end else if (clearEr) begin
            abortReported <= 1'b0;
        end
    end

    // interrupt level stays up until software clears the record valid bit
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            faultPend <= 1'b0;
        end else if (raiseIrq) begin
            faultPend <= 1'b1;
        end else if (clearValid) begin
            faultPend <= 1'b0;
        end
    end

    // registered outputs: interrupt level and a one-cycle abort pulse
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            faultIrq <= 1'b0;
            abortResp <= 1'b0;
        end else begin
            faultIrq <= faultPend;
            abortResp <= abortNow;
        end
    end

    // read mux; the feature word is fixed since the control set is fixed
    always @* begin
        next_rdata = 32'h0000_0000;
        next_rhit = 1'b1;
        case (araddr)
            `ENG_OFF_FEATURE: begin
                next_rdata = featureWord;
            end
            `ENG_OFF_CONTROL: begin
                next_rdata[3:0] = ctl;
            end
            `ENG_OFF_STATUS: begin
                next_rdata[`ENG_ST_VALID] = recValid;
                next_rdata[`ENG_ST_ER] = abortReported;
                next_rdata[`ENG_ST_CLASS_HI:`ENG_ST_CLASS_LO] = recClass;
                next_rdata[`ENG_ST_SYN_HI:`ENG_ST_SYN_LO] = recSyndrome;
            end
            `ENG_OFF_COUNTER: begin
                next_rdata[7:0] = ceCount;
                next_rdata[`ENG_CNT_OVERFLOW] = ceOverflow;
            end
            default: begin
                next_rhit = 1'b0;
            end
        endcase
    end

    // read data is taken in the address cycle and held until rready
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `ENG_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rhit ? `ENG_RESP_OKAY : `ENG_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

// File: sim/eng_gating_monitor.sv
`timescale 1ns/10ps
module eng_gating_monitor (
    // clock and reset
    input wire clk,
    input wire nrst,
    // register bus
    input wire awready,
    input wire wready,
    input wire bvalid,
    input wire bready,
    input wire arready,
    input wire rvalid,
    input wire rready,
    input wire [31:0] rdata,
    // error port and outputs
    input wire errValid,
    input wire [1:0] errClass,
    input wire faultIrq,
    input wire abortResp
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // no uncorrected record this cycle; a write response taken
    sequence sNoUe;
        !errValid || errClass != 2'h3;
    endsequence
    sequence sBTaken;
        bvalid && bready;
    endsequence
    AST_ABORT_CAUSE: assert property (sNoUe |=> !abortResp) else $error("stray abort");
    AST_IRQ_CAUSE: assert property ($rose(faultIrq) |-> $past(errValid, 2))
        else $error("irq without record");
    // the level only drops after software wrote the status
    AST_IRQ_HOLD: assert property ($fell(faultIrq) |-> $past(bvalid) || $past(bvalid, 2)
        || $past(bvalid, 3)) else $error("irq dropped early");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data moved");
    AST_B_BLOCK: assert property (bvalid |-> !awready && !wready) else $error("write overlap");
    AST_R_BLOCK: assert property (arready != rvalid) else $error("read overlap");
    AST_B_DONE: assert property (sBTaken |=> !bvalid && awready && wready)
        else $error("write not freed");
endmodule
bind eng_irq_abort_gating eng_gating_monitor mon (.clk(clk), .nrst(nrst), .awready(awready),
    .wready(wready), .bvalid(bvalid), .bready(bready), .arready(arready), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .errValid(errValid), .errClass(errClass),
    .faultIrq(faultIrq), .abortResp(abortResp));

// File: sim/eng_fault_partner.sv
`timescale 1ns/10ps
module eng_fault_partner (
    // clock and reset
    input wire clk,
    input wire nrst,
    // abort seen by the requester
    input wire abortResp,
    // aborts taken so far
    output reg [7:0] abortCount
);
    // each pulse ends one access, so a plain count of the cycles with abortResp high is the abort tally
    always @(posedge clk or negedge nrst) begin
        if (!nrst)
            abortCount <= 8'h00;
        else if (abortResp)
            abortCount <= abortCount + 8'h01;
    end
endmodule

// File: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic errValid = 0, errIsWrite = 0, w;
    logic [7:0] awaddr = 0, araddr = 0, errSyndrome = 0, expAb = 0;
    logic [31:0] wdata = 0, rdv;
    logic [3:0] wstrb = 0, ctl;
    logic [1:0] errClass = 0, rsv, c;
    wire awready, wready, bvalid, arready, rvalid, faultIrq, abortResp;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] abortCount;
    int miscompares = 0, samples_checked = 0, cyc = 0, i, n;

    eng_irq_abort_gating DUT (.clk(clk), .nrst(nrst), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .errValid(errValid), .errClass(errClass), .errIsWrite(errIsWrite),
        .errSyndrome(errSyndrome), .faultIrq(faultIrq), .abortResp(abortResp));
    eng_fault_partner peer (.clk(clk), .nrst(nrst), .abortResp(abortResp),
        .abortCount(abortCount));

    initial begin
        forever #5 clk = ~clk;
    end
    // ceiling against a hung handshake
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    // expected abort and interrupt from class, direction and enables
    function automatic logic expAbort(logic [1:0] k, logic d, logic [3:0] e);
        return k == 2'h3 && (d ? e[3] : e[2]);
    endfunction
    function automatic logic expIrq(logic [1:0] k, logic [3:0] e);
        return k[1] && e[0];
    endfunction
    task print_verdict();
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] ex);
        samples_checked++;
        if (got !== ex) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, ex);
        end
    endtask
    // bready is raised 0 to 2 cycles late at random so the response waits a cycle when the delay is 2
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, wd;
        aw = 0;
        wd = 0;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1;
        wvalid <= 1;
        while (!(aw && wd) && n < 50) begin
            @(posedge clk);
            n++;
            aw = aw | awready;
            wd = wd | wready;
            if (aw) awvalid <= 0;
            if (wd) wvalid <= 0;
        end
        repeat ($urandom % 3) @(posedge clk);
        bready <= 1;
        do @(posedge clk); while (!bvalid && ++n < 90);
        rsv = bresp;
        bready <= 0;
    endtask
    task rd(input logic [7:0] a);
        n = 0;
        araddr <= a;
        arvalid <= 1;
        do @(posedge clk); while (!arready && ++n < 50);
        arvalid <= 0;
        repeat ($urandom % 3) @(posedge clk);
        rready <= 1;
        do @(posedge clk); while (!rvalid && ++n < 90);
        rdv = rdata;
        rsv = rresp;
        rready <= 0;
    endtask
    // one-cycle error report; abort a cycle later, interrupt level one more
    task err(input logic [1:0] k, input logic d, input logic ea, input logic ei);
        errValid <= 1;
        errClass <= k;
        errIsWrite <= d;
        errSyndrome <= $urandom;
        expAb = expAb + ea;
        @(posedge clk);
        errValid <= 0;
        #1 chk(abortResp, ea);
        @(posedge clk);
        #1 chk(faultIrq, ei);
    endtask

    initial begin
        i = $urandom(1);
        repeat (5) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        rd(8'h00);
        chk(rdv, 32'h0000_007F);
        rd(8'h20);
        chk(rsv, 32'h0000_0002);
        wr(8'h24, 32'h0000_000F);
        chk(rsv, 32'h0000_0002);
        // enables are clear out of reset
        err(2'h3, 1, 0, 0);
        $display("test registers done");
        wr(8'h10, 32'h0000_0003);
        wr(8'h08, 32'h0000_000D);
        err(2'h3, 1, 1, 1);
        err(2'h2, 0, 0, 1);
        rd(8'h10);
        chk(rdv[5:0], 32'h0000_0033);
        #1 chk(faultIrq, 1);
        wr(8'h10, 32'h0000_0003);
        repeat (3) @(posedge clk);
        #1 chk(faultIrq, 0);
        // split abort enable: reads only
        wr(8'h08, 32'h0000_0005);
        err(2'h3, 1, 0, 1);
        err(2'h3, 0, 1, 1);
        $display("test enables done");
        // counter wrap is the corrected event
        wr(8'h10, 32'h0000_0003);
        wr(8'h08, 32'h0000_0001);
        wr(8'h18, 32'h0000_00FF);
        err(2'h1, 0, 0, 0);
        rd(8'h18);
        chk(rdv, 32'h0000_0100);
        wr(8'h10, 32'h0000_0003);
        wr(8'h08, 32'h0000_0003);
        wr(8'h18, 32'h0000_00FE);
        err(2'h1, 0, 0, 0);
        err(2'h1, 0, 0, 1);
        wr(8'h10, 32'h0000_0003);
        wr(8'h18, 32'h0000_01FF);
        err(2'h1, 0, 0, 0);
        $display("test counter done");
        for (i = 0; i < 24; i++) begin
            ctl = $urandom;
            c = $urandom;
            w = $urandom;
            wr(8'h10, 32'h0000_0003);
            wr(8'h08, {28'h000_0000, ctl});
            err(c, w, expAbort(c, w, ctl), expIrq(c, ctl));
        end
        chk(abortCount, expAb);
        $display("test random done");
        print_verdict();
    end
endmodule
